// file: core/adc_ctrl.sv
// converter mode sequencing, result formatting, auto buffers and apb register file
`timescale 1ns/1ps
module adc_ctrl
  import adc_pkg::*;
#(
  parameter int unsigned DLY_UNIT_CYC = 8
) (
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADC_AW-1:0] paddr_in,
  input  wire logic [ADC_DW-1:0] pwdata_in,
  output logic      [ADC_DW-1:0] prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              blank_in,
  input  wire logic              conv_done_in,
  input  wire logic [11:0]       conv_data_in,
  output logic                   conv_start_out,
  output logic                   conv_power_out,
  output adc_sel_s               conv_sel_out,
  output logic [1:0]             ref_select_out,
  output logic [2:0]             conv_clock_select_out,
  output logic [4:0]             blanking_time_out
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // place a 12-bit result into the 16-bit high/low pair
  function automatic logic [ADC_BUF_W-1:0] fmt_result(input logic align, input logic [ADC_RES_W-1:0] res);
    if (align) begin
      fmt_result = {ADC_NIB_ZERO, res};
    end else begin
      fmt_result = {res, ADC_NIB_ZERO};
    end
  endfunction

  // true for every mapped register offset
  function automatic logic reg_hit(input logic [ADC_AW-1:0] a);
    reg_hit = (a == ADC_OFS_CTRL0) || (a == ADC_OFS_CTRL1) || (a == ADC_OFS_RES_LO) ||
              (a == ADC_OFS_RES_HI) || (a == ADC_OFS_BUF1_HI) || (a == ADC_OFS_BUF1_LO) ||
              (a == ADC_OFS_BUF2_HI) || (a == ADC_OFS_BUF2_LO) || (a == ADC_OFS_AUTO) ||
              (a == ADC_OFS_CH1) || (a == ADC_OFS_CH2) || (a == ADC_OFS_DELAY);
  endfunction

  // channel-register source to mux steering; kind 1 means internal source code
  function automatic adc_sel_s chan_sel(input logic kind, input logic [3:0] code);
    chan_sel.int_src     = kind ? code[2:0] : ADC_INT_NONE;
    chan_sel.ext_ch      = code;
    chan_sel.ext_connect = 1'b0;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state

  adc_state_s q;
  adc_state_s n;

  logic       setup;
  logic       wr;
  logic       auto_mode;
  logic       two_ch;
  logic       align_eff;
  logic       start_fall;
  logic       blank_fall;
  logic       trig;
  logic [7:0] rd_mux;
  logic [7:0] wb;
  logic [ADC_BUF_W-1:0] res_fmt;

  // mode decode from the registered control bytes
  assign auto_mode  = q.automode[ADC_AM_MODE_HI:ADC_AM_MODE_LO] != ADC_MODE_MAN;
  assign two_ch     = auto_mode & q.ch1[ADC_CH1_TWO];
  assign align_eff  = auto_mode | q.ctrl0[ADC_C0_ALIGN];
  assign start_fall = q.start_prev & ~q.ctrl0[ADC_C0_START];
  assign blank_fall = q.blank_prev & ~blank_in;
  // auto start needs its arm bit; manual start is a 1 then 0 on the start bit
  assign trig       = q.ctrl0[ADC_C0_EN] &
                      ((~auto_mode & start_fall) | (auto_mode & q.automode[ADC_AM_START] & blank_fall));
  assign setup      = psel_in & ~penable_in;
  assign wr         = psel_in & penable_in & pwrite_in;
  assign wb         = pwdata_in[7:0];
  // formatted result pair, split into bytes by the read multiplexer
  assign res_fmt    = fmt_result(align_eff, q.result);

  // read data multiplexer, sampled during the setup cycle
  always_comb begin
    rd_mux = 8'h00;
    unique case (paddr_in)
      ADC_OFS_CTRL0:   rd_mux = {q.ctrl0[ADC_C0_START], q.busy, q.ctrl0[ADC_C0_EN], align_eff, q.ctrl0[3:0]};
      ADC_OFS_CTRL1:   rd_mux = q.ctrl1;
      ADC_OFS_RES_LO:  rd_mux = res_fmt[7:0];
      ADC_OFS_RES_HI:  rd_mux = res_fmt[15:8];
      ADC_OFS_BUF1_HI: rd_mux = q.buf1[15:8];
      ADC_OFS_BUF1_LO: rd_mux = q.shadow1;
      ADC_OFS_BUF2_HI: rd_mux = q.buf2[15:8];
      ADC_OFS_BUF2_LO: rd_mux = q.shadow2;
      ADC_OFS_AUTO:    rd_mux = q.automode;
      ADC_OFS_CH1:     rd_mux = {2'h0, q.ch1};
      ADC_OFS_CH2:     rd_mux = {3'h0, q.ch2};
      ADC_OFS_DELAY:   rd_mux = {4'h0, q.delay};
      default:         rd_mux = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n            = q;
    n.kick       = 1'b0;
    n.start_prev = q.ctrl0[ADC_C0_START];
    n.blank_prev = blank_in;

    // apb setup: capture answer; a high-byte buffer read freezes its low byte
    if (setup) begin
      n.rerr  = ~reg_hit(paddr_in);
      n.rdata = pwrite_in ? 8'h00 : rd_mux;
      if (!pwrite_in && paddr_in == ADC_OFS_BUF1_HI) begin
        n.shadow1 = q.buf1[7:0];
      end
      if (!pwrite_in && paddr_in == ADC_OFS_BUF2_HI) begin
        n.shadow2 = q.buf2[7:0];
      end
    end

    // apb writes; busy and the data registers are not writable
    if (wr) begin
      unique case (paddr_in)
        ADC_OFS_CTRL0: begin
          n.ctrl0 = {wb[ADC_C0_START], 1'b0, wb[ADC_C0_EN],
                     auto_mode ? q.ctrl0[ADC_C0_ALIGN] : wb[ADC_C0_ALIGN], wb[3:0]};
        end
        ADC_OFS_CTRL1: n.ctrl1    = wb;
        ADC_OFS_AUTO:  n.automode = wb;
        ADC_OFS_CH1:   n.ch1      = wb[5:0];
        ADC_OFS_CH2:   n.ch2      = wb[4:0];
        ADC_OFS_DELAY: n.delay    = wb[3:0];
        default: ;
      endcase
    end

    // conversion sequencer
    unique case (q.st)
      ADC_ST_IDLE: begin
        if (trig) begin
          n.kick = 1'b1;
          n.busy = 1'b1;
          n.st   = ADC_ST_CONV1;
        end
      end
      ADC_ST_CONV1: begin
        if (conv_done_in) begin
          n.result = conv_data_in;
          n.busy   = 1'b0;
          if (auto_mode) begin
            n.buf1 = fmt_result(1'b1, conv_data_in);
          end
          if (two_ch) begin
            n.st   = ADC_ST_GAP;
            n.dcnt = ADC_DCNT_W'(q.delay * DLY_UNIT_CYC);
          end else begin
            n.st = ADC_ST_IDLE;
          end
        end
      end
      ADC_ST_GAP: begin
        // the inter-channel wait; a zero delay still costs one cycle here
        if (q.dcnt == '0) begin
          n.kick = 1'b1;
          n.busy = 1'b1;
          n.st   = ADC_ST_CONV2;
        end else begin
          n.dcnt = q.dcnt - ADC_DCNT_W'(1);
        end
      end
      ADC_ST_CONV2: begin
        if (conv_done_in) begin
          n.result = conv_data_in;
          n.buf2   = fmt_result(1'b1, conv_data_in);
          n.busy   = 1'b0;
          n.st     = ADC_ST_IDLE;
        end
      end
    endcase

    // disabling powers the core down and abandons any conversion, result kept
    if (!n.ctrl0[ADC_C0_EN]) begin
      n.st   = ADC_ST_IDLE;
      n.busy = 1'b0;
      n.kick = 1'b0;
    end

    // mux steering for the conversion now running or about to run
    if (two_ch) begin
      n.sel = (n.st == ADC_ST_GAP || n.st == ADC_ST_CONV2) ?
              chan_sel(n.ch2[ADC_CH_KIND], n.ch2[3:0]) :
              chan_sel(n.ch1[ADC_CH_KIND], n.ch1[3:0]);
    end else begin
      n.sel.int_src = n.ctrl1[7:5];
      n.sel.ext_ch  = n.ctrl0[3:0];
    end
    n.sel.ext_connect = n.ctrl0[ADC_C0_EN] & (n.sel.int_src == ADC_INT_NONE);
  end

  // single register stage for the whole state
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      q <= ADC_STATE_RST;
    end else begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero-wait slave: every access phase completes at once
  assign pready_out            = 1'b1;
  assign pslverr_out           = psel_in & penable_in & q.rerr;
  assign prdata_out            = {{(ADC_DW-8){1'b0}}, q.rdata};
  assign conv_start_out        = q.kick;
  assign conv_power_out        = q.ctrl0[ADC_C0_EN];
  assign conv_sel_out          = q.sel;
  assign ref_select_out        = q.ctrl1[4:3];
  assign conv_clock_select_out = q.ctrl1[2:0];
  assign blanking_time_out     = q.automode[4:0];

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  sequence s_idle_manual_pulse;
    (q.st == ADC_ST_IDLE) && q.ctrl0[ADC_C0_EN] && !auto_mode && start_fall;
  endsequence

  sequence s_ch1_done;
    (q.st == ADC_ST_CONV1) && conv_done_in && q.ctrl0[ADC_C0_EN];
  endsequence

  sequence s_ch2_done;
    (q.st == ADC_ST_CONV2) && conv_done_in && q.ctrl0[ADC_C0_EN];
  endsequence

  AST_MANUAL_START: assert property (s_idle_manual_pulse ##0 !wr |=> conv_start_out && q.busy)
    else $error("manual start pulse did not start a conversion");

  AST_AUTO_IGNORES_START: assert property (auto_mode && !blank_fall && q.st == ADC_ST_IDLE |=> !conv_start_out)
    else $error("conversion started in auto mode without blanking edge");

  AST_BUSY_WITH_START: assert property (conv_start_out |-> q.busy)
    else $error("busy not set at conversion start");

  AST_BUSY_CLEARS: assert property (s_ch1_done ##0 !two_ch |=> !q.busy && q.st == ADC_ST_IDLE)
    else $error("busy not cleared after conversion finished");

  AST_ALIGN0_LOW: assert property (setup && !pwrite_in && paddr_in == ADC_OFS_RES_LO && !align_eff
                                   |=> prdata_out[3:0] == 4'h0 && prdata_out[7:4] == $past(q.result[3:0]))
    else $error("left aligned low byte wrong");

  AST_AUTO_HIGH_NIBBLE: assert property (setup && !pwrite_in && paddr_in == ADC_OFS_RES_HI && auto_mode
                                         |=> prdata_out[7:4] == 4'h0 && prdata_out[3:0] == $past(q.result[11:8]))
    else $error("auto mode result not right aligned");

  AST_HOLD_DISABLED: assert property (!q.ctrl0[ADC_C0_EN] |=> $stable(q.result))
    else $error("result changed while converter disabled");

  AST_BUF1_COPY: assert property (s_ch1_done ##0 auto_mode |=> q.buf1 == {4'h0, $past(conv_data_in)})
    else $error("buffer 1 not loaded from first-channel result");

  AST_BUF2_COPY: assert property (s_ch2_done |=> q.buf2 == {4'h0, $past(conv_data_in)} && !q.busy)
    else $error("buffer 2 not loaded from second-channel result");

  AST_EXT_OFF: assert property (conv_sel_out.int_src != ADC_INT_NONE |-> !conv_sel_out.ext_connect)
    else $error("external input left connected with internal source");

  AST_NO_POWER_NO_START: assert property (!conv_power_out |-> !conv_start_out && !q.busy)
    else $error("conversion active while powered down");

  AST_GAP_ZERO_DELAY: assert property (s_ch1_done ##0 two_ch && q.delay == 4'h0 && !wr
                                       |=> q.st == ADC_ST_GAP ##1 conv_start_out)
    else $error("second channel did not start after zero delay");

  AST_SHADOW_LATCH: assert property (setup && !pwrite_in && paddr_in == ADC_OFS_BUF1_HI
                                     |=> q.shadow1 == $past(q.buf1[7:0]))
    else $error("buffer 1 low byte not frozen by high byte read");

endmodule // adc_ctrl

// file: core/adc_pkg.sv
// constants, types and state layout for the converter mode and result controller
package adc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // bus geometry and register byte offsets
  localparam int         ADC_AW           = 8;
  localparam int         ADC_DW           = 32;
  localparam logic [7:0] ADC_OFS_CTRL0    = 8'h00;
  localparam logic [7:0] ADC_OFS_CTRL1    = 8'h04;
  localparam logic [7:0] ADC_OFS_RES_LO   = 8'h08;
  localparam logic [7:0] ADC_OFS_RES_HI   = 8'h0C;
  localparam logic [7:0] ADC_OFS_BUF1_HI  = 8'h10;
  localparam logic [7:0] ADC_OFS_BUF1_LO  = 8'h14;
  localparam logic [7:0] ADC_OFS_BUF2_HI  = 8'h18;
  localparam logic [7:0] ADC_OFS_BUF2_LO  = 8'h1C;
  localparam logic [7:0] ADC_OFS_AUTO     = 8'h20;
  localparam logic [7:0] ADC_OFS_CH1      = 8'h24;
  localparam logic [7:0] ADC_OFS_CH2      = 8'h28;
  localparam logic [7:0] ADC_OFS_DELAY    = 8'h2C;

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int ADC_C0_START   = 7;
  localparam int ADC_C0_BUSY    = 6;
  localparam int ADC_C0_EN      = 5;
  localparam int ADC_C0_ALIGN   = 4;
  localparam int ADC_AM_START   = 7;
  localparam int ADC_AM_MODE_HI = 6;
  localparam int ADC_AM_MODE_LO = 5;
  localparam int ADC_CH1_TWO    = 5;
  localparam int ADC_CH_KIND    = 4;

  //////////////////////////////////////////////////////////////////////////////
  // widths and fixed codes
  localparam int          ADC_RES_W     = 12;
  localparam int          ADC_BUF_W     = 16;
  localparam int          ADC_DCNT_W    = 12;
  localparam logic [1:0]  ADC_MODE_MAN  = 2'h0;
  localparam logic [2:0]  ADC_INT_NONE  = 3'h0;
  localparam logic [3:0]  ADC_NIB_ZERO  = 4'h0;

  // sequencer states, gray along idle -> ch1 -> gap -> ch2 -> idle
  typedef enum logic [1:0] {
    ADC_ST_IDLE  = 2'b00,
    ADC_ST_CONV1 = 2'b01,
    ADC_ST_GAP   = 2'b11,
    ADC_ST_CONV2 = 2'b10
  } adc_state_e;

  // analog multiplexer steering toward the converter core
  typedef struct packed {
    logic [2:0] int_src;
    logic [3:0] ext_ch;
    logic       ext_connect;
  } adc_sel_s;

  // whole state of the controller
  typedef struct packed {
    logic [7:0]            ctrl0;
    logic [7:0]            ctrl1;
    logic [7:0]            automode;
    logic [5:0]            ch1;
    logic [4:0]            ch2;
    logic [3:0]            delay;
    logic                  busy;
    logic [ADC_RES_W-1:0]  result;
    logic [ADC_BUF_W-1:0]  buf1;
    logic [ADC_BUF_W-1:0]  buf2;
    logic [7:0]            shadow1;
    logic [7:0]            shadow2;
    adc_state_e            st;
    logic [ADC_DCNT_W-1:0] dcnt;
    logic                  start_prev;
    logic                  blank_prev;
    logic                  kick;
    adc_sel_s              sel;
    logic [7:0]            rdata;
    logic                  rerr;
  } adc_state_s;

  localparam adc_state_s ADC_STATE_RST = '0;

endpackage

// file: dv/adc_core_model.sv
// behavioural converter core that answers each start pulse with one result
`timescale 1ns/1ps
module adc_core_model (
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        start_in,
  input  wire logic        power_in,
  input  wire logic [7:0]  lat_in,
  input  wire logic [11:0] next_in,
  output logic             done_out,
  output logic [11:0]      data_out
);
  logic [7:0]  cnt_q;
  logic [11:0] held_q;

  //////////////////////////////////////////////////////////////////////////////
  // data toggles outside the done cycle so a stale value is never mistaken for a result
  always_ff @(posedge mclk_in) begin
    done_out <= 1'b0;
    data_out <= ~data_out;
    if (reset_in) begin
      cnt_q    <= 8'h00;
      data_out <= 12'h000;
    end else if (!power_in) begin
      cnt_q <= 8'h00;
    end else if (start_in) begin
      cnt_q  <= lat_in;
      held_q <= next_in;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        done_out <= 1'b1;
        data_out <= held_q;
      end
    end
  end
endmodule // adc_core_model

// file: dv/adc_ctrl_tb.sv
// self-checking bench for the converter mode and result controller
`timescale 1ns/1ps
module adc_ctrl_tb;
  import adc_pkg::*;
  typedef struct {string nm; logic [31:0] ex; logic er;} adc_note_s;
  logic              mclk_in, reset_in, psel, penable, pwrite, pready, pslverr, blank, cdone, cstart, cpower;
  logic [7:0]        paddr, lat;
  logic [31:0]       pwdata, prdata;
  logic [11:0]       cdata, dnext;
  logic [1:0]        refsel;
  logic [2:0]        clksel;
  logic [4:0]        blanksel;
  adc_sel_s          csel;
  adc_note_s         q[$];
  int                failures, check_count, cyc;

  //////////////////////////////////////////////////////////////////////////////
  // design, converter core and clock
  adc_ctrl #(.DLY_UNIT_CYC(1)) dut (.mclk_in(mclk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .blank_in(blank), .conv_done_in(cdone), .conv_data_in(cdata), .conv_start_out(cstart),
    .conv_power_out(cpower), .conv_sel_out(csel), .ref_select_out(refsel), .conv_clock_select_out(clksel),
    .blanking_time_out(blanksel));
  adc_core_model core (.mclk_in(mclk_in), .reset_in(reset_in), .start_in(cstart), .power_in(cpower),
    .lat_in(lat), .next_in(dnext), .done_out(cdone), .data_out(cdata));
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one apb transfer; the request holds until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [7:0] d, string nm, logic [31:0] ex, logic er);
    if (!w) q.push_back('{nm, ex, er});
    @(posedge mclk_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
    @(posedge mclk_in);
    penable <= 1'b1;
    @(posedge mclk_in);
    // only the bench timeout ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge mclk_in);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    apb(1'b1, a, d, "", 32'h0, 1'b0);
  endtask
  task automatic rd(string nm, logic [7:0] a, logic [7:0] ex);
    apb(1'b0, a, 8'h00, nm, {24'h000000, ex}, 1'b0);
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  task automatic wait_sig(bit done, output adc_sel_s s);
    int n;
    n = 0;
    @(posedge mclk_in);
    while ((done ? cdone : cstart) !== 1'b1 && n < 300) begin
      n++;
      @(posedge mclk_in);
    end
    if (n == 300) chk("handshake", 32'h1, 32'h0);
    s = csel;
  endtask
  task automatic no_start(int cycles);
    repeat (cycles) begin
      @(posedge mclk_in);
      chk("idle_start", 32'h0, {31'h0, cstart});
    end
  endtask
  task automatic blank_pulse();
    @(posedge mclk_in);
    blank <= 1'b1;
    @(posedge mclk_in);
    blank <= 1'b0;
  endtask
  task automatic conclude();
    // a read note never matched means a read that was never answered
    if (q.size() != 0) failures++;
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // read monitor: each completed read is compared against the oldest note
  always @(posedge mclk_in) begin : mon
    adc_note_s n;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (q.size() == 0) chk("note", 32'h1, 32'h0);
      else begin
        n = q.pop_front();
        chk({n.nm, "_err"}, {31'h0, n.er}, {31'h0, pslverr});
        if (!n.er) chk(n.nm, n.ex, prdata);
      end
    end
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin : main
    logic [15:0] rnd;
    logic [11:0] d, d2, e1;
    adc_sel_s    s;
    time         t0;
    {psel, penable, pwrite, blank, paddr, pwdata, lat, dnext} = '0;
    failures = 0; check_count = 0; cyc = 0; rnd = 16'h002F;
    reset_in = 1'b1;
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd("ctrl0_rst", ADC_OFS_CTRL0, 8'h00);
    apb(1'b0, 8'h30, 8'h00, "unmapped", 32'h0, 1'b1);
    // manual start with two-channel enable set, slow core
    wr(ADC_OFS_CH1, 8'h20);
    wr(ADC_OFS_CTRL0, 8'h23);
    settle();
    chk("power_on", 32'h1, {31'h0, cpower});
    chk("sel_ext", 32'h7, {24'h0, csel});
    rnd = lfsr_next(rnd); d = rnd[11:0]; dnext <= d; lat <= 8'h0C;
    wr(ADC_OFS_CTRL0, 8'hA3);
    wr(ADC_OFS_CTRL0, 8'h23);
    wait_sig(1'b0, s);
    rd("busy_set", ADC_OFS_CTRL0, 8'h63);
    wait_sig(1'b1, s);
    rd("busy_clr", ADC_OFS_CTRL0, 8'h23);
    rd("res_hi_a0", ADC_OFS_RES_HI, d[11:4]);
    rd("res_lo_a0", ADC_OFS_RES_LO, {d[3:0], 4'h0});
    wr(ADC_OFS_CTRL0, 8'h33);
    rd("res_hi_a1", ADC_OFS_RES_HI, {4'h0, d[11:8]});
    wr(ADC_OFS_RES_LO, 8'hFF);
    rd("res_lo_a1", ADC_OFS_RES_LO, d[7:0]);
    // internal source, then disable
    wr(ADC_OFS_CTRL1, 8'h55);
    settle();
    chk("sel_int", {29'h0, 3'h2}, {29'h0, csel.int_src});
    chk("ext_off", 32'h0, {31'h0, csel.ext_connect});
    chk("ref_clk", 32'h15, {27'h0, refsel, clksel});
    wr(ADC_OFS_CTRL0, 8'h13);
    settle();
    chk("power_off", 32'h0, {31'h0, cpower});
    wr(ADC_OFS_CTRL0, 8'h93);
    wr(ADC_OFS_CTRL0, 8'h13);
    no_start(20);
    rd("res_keep", ADC_OFS_RES_HI, {4'h0, d[11:8]});
    // 1-channel auto in every auto mode code (1 to 3), prompt core, software alignment 0
    wr(ADC_OFS_CTRL1, 8'h00);
    wr(ADC_OFS_CH1, 8'h00);
    wr(ADC_OFS_CTRL0, 8'h23);
    lat <= 8'h01;
    for (int m = 1; m < 4; m++) begin
      rnd = lfsr_next(rnd); d = rnd[11:0]; dnext <= d;
      wr(ADC_OFS_AUTO, {1'b1, m[1:0], 5'h0B});
      blank_pulse();
      wait_sig(1'b0, s);
      wait_sig(1'b1, s);
      chk("blank_time", 32'h0B, {27'h0, blanksel});
      rd("buf1_hi", ADC_OFS_BUF1_HI, {4'h0, d[11:8]});
      rd("buf1_lo", ADC_OFS_BUF1_LO, d[7:0]);
      rd("res_forced", ADC_OFS_RES_HI, {4'h0, d[11:8]});
    end
    wr(ADC_OFS_CTRL0, 8'hA3);
    wr(ADC_OFS_CTRL0, 8'h23);
    no_start(20);
    // 2-channel auto, two rounds, buffer 2 high read between them
    wr(ADC_OFS_CH1, 8'h25);
    wr(ADC_OFS_CH2, 8'h12);
    for (int r = 0; r < 2; r++) begin
      // second round uses a zero gap, the shortest spacing between channels
      wr(ADC_OFS_DELAY, (r == 0) ? 8'h02 : 8'h00);
      rnd = lfsr_next(rnd); d = rnd[11:0];
      rnd = lfsr_next(rnd); d2 = rnd[11:0]; dnext <= d;
      blank_pulse();
      wait_sig(1'b0, s);
      chk("sel_ch1", 32'h0B, {24'h0, s});
      dnext <= d2;
      wait_sig(1'b1, s);
      t0 = $time;
      wait_sig(1'b0, s);
      chk("gap_len", (r == 0) ? 32'd4 : 32'd2, 32'(($time - t0) / 8));
      chk("sel_ch2", 32'h4, {28'h0, s.int_src, s.ext_connect});
      wait_sig(1'b1, s);
      if (r == 0) begin
        e1 = d2;
        rd("buf2_hi0", ADC_OFS_BUF2_HI, {4'h0, d2[11:8]});
      end
    end
    rd("buf2_lo_held", ADC_OFS_BUF2_LO, e1[7:0]);
    rd("buf1_hi2", ADC_OFS_BUF1_HI, {4'h0, d[11:8]});
    rd("buf1_lo2", ADC_OFS_BUF1_LO, d[7:0]);
    rd("buf2_hi2", ADC_OFS_BUF2_HI, {4'h0, d2[11:8]});
    rd("buf2_lo2", ADC_OFS_BUF2_LO, d2[7:0]);
    repeat (4) @(posedge mclk_in);
    conclude();
  end
endmodule // adc_ctrl_tb
